// ==== design/edmb_ctrl.sv ====
`default_nettype none
module edmb_ctrl
	import edmb_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_in,
	// Core side
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic req_bank_y_in,
	input wire logic [15:0] req_addr_in,
	input wire logic [15:0] req_wdata_in,
	output logic req_ready_out,
	output logic rsp_valid_out,
	output logic [15:0] rsp_rdata_out,
	// Pin side
	input wire logic wait_in,
	input wire logic bus_hold_request_n_in,
	output logic bus_hold_grant_n_out,
	output logic bus_occupied_strobe_n_out,
	output logic bank_select_out,
	output logic bank_select_oe_out,
	output logic [15:0] data_memory_address_out,
	output logic data_memory_address_oe_out,
	input wire logic [15:0] data_memory_bus_in,
	output logic [15:0] data_memory_bus_out,
	output logic data_memory_bus_oe_out,
	output logic memory_read_strobe_n_out,
	output logic memory_write_strobe_n_out,
	output logic strobes_oe_out
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	edmb_sync_if sync_bus ();
	assign sync_bus.wait_raw = wait_in;
	assign sync_bus.hold_req_n_raw = bus_hold_request_n_in;
	edmb_pin_sync u_sync (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.sync_bus(sync_bus.syncer)
	);
	wire logic wait_s = sync_bus.wait_sync;
	wire logic hold_wanted = ~sync_bus.hold_req_n_sync;

	// ------------------------------------------------------------
	// State and held bus values
	// ------------------------------------------------------------
	edmb_state_e state_reg;
	edmb_state_e state_next;
	logic [15:0] addr_reg;
	logic [15:0] addr_next;
	logic bank_reg;
	logic bank_next;
	logic write_reg;
	logic write_next;
	logic [15:0] wdata_reg;
	logic [15:0] wdata_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic rsp_reg;
	logic rsp_next;
	logic strobe_aged_reg;
	logic strobe_aged_next;

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	wire logic is_idle = (state_reg == EDMB_IDLE);
	wire logic is_held = (state_reg == EDMB_HELD);
	wire logic strobing = (state_reg == EDMB_STROBE);
	wire logic in_access = (state_reg == EDMB_SETUP) || strobing;
	// Hold beats a new request; an access in flight is never cut short
	wire logic grant_now = is_idle && hold_wanted;
	wire logic start_access = is_idle && !hold_wanted && req_valid_in;
	wire logic read_strobe = strobing && !write_reg;
	wire logic write_strobe = strobing && write_reg;
	// Wait lags the pin by two edges, so a read strobes twice before it may end
	wire logic read_may_end = strobe_aged_reg && !wait_s;
	// Wait only stretches reads; writes ignore it
	wire logic strobe_done = write_strobe || (read_strobe && read_may_end);
	wire logic read_lands = read_strobe && read_may_end;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			EDMB_IDLE: begin
				if (grant_now)
					state_next = EDMB_HELD;
				else if (start_access)
					state_next = EDMB_SETUP;
			end
			EDMB_SETUP: state_next = EDMB_STROBE;
			EDMB_STROBE: begin
				if (strobe_done)
					state_next = EDMB_IDLE;
			end
			EDMB_HELD: begin
				if (!hold_wanted)
					state_next = EDMB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in)
			state_reg <= EDMB_IDLE;
		else
			state_reg <= state_next;
	end

	// ------------------------------------------------------------
	// Address and bank capture
	// ------------------------------------------------------------
	// Loaded only at access start, so the lines hold between accesses
	assign addr_next = start_access ? req_addr_in : addr_reg;
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in)
			addr_reg <= EDMB_ADDR_RESET;
		else
			addr_reg <= addr_next;
	end

	wire logic bank_pick = req_bank_y_in ? EDMB_BANK_Y : EDMB_BANK_X;
	assign bank_next = start_access ? bank_pick : bank_reg;
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in)
			bank_reg <= EDMB_BANK_X;
		else
			bank_reg <= bank_next;
	end

	// ------------------------------------------------------------
	// Direction and write data capture
	// ------------------------------------------------------------
	assign write_next = start_access ? req_write_in : write_reg;
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in)
			write_reg <= 1'b0;
		else
			write_reg <= write_next;
	end

	assign wdata_next = start_access ? req_wdata_in : wdata_reg;
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in)
			wdata_reg <= EDMB_DATA_RESET;
		else
			wdata_reg <= wdata_next;
	end

	// ------------------------------------------------------------
	// Read return
	// ------------------------------------------------------------
	// Taken on the last strobe cycle, while the memory still drives
	assign rdata_next = read_lands ? data_memory_bus_in : rdata_reg;
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in)
			rdata_reg <= EDMB_DATA_RESET;
		else
			rdata_reg <= rdata_next;
	end

	assign rsp_next = strobe_done;
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in)
			rsp_reg <= 1'b0;
		else
			rsp_reg <= rsp_next;
	end

	// ------------------------------------------------------------
	// Read strobe timing
	// ------------------------------------------------------------
	// Marks a strobe past its first cycle; cleared as the access ends
	assign strobe_aged_next = strobing && !strobe_done;
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in)
			strobe_aged_reg <= 1'b0;
		else
			strobe_aged_reg <= strobe_aged_next;
	end

	// ------------------------------------------------------------
	// Core handshake
	// ------------------------------------------------------------
	assign req_ready_out = is_idle && !hold_wanted;
	assign rsp_valid_out = rsp_reg;
	assign rsp_rdata_out = rdata_reg;

	// ------------------------------------------------------------
	// Hold and bus strobe
	// ------------------------------------------------------------
	assign bus_hold_grant_n_out = ~is_held;
	assign bus_occupied_strobe_n_out = ~in_access;

	// ------------------------------------------------------------
	// Output enables
	// ------------------------------------------------------------
	wire logic drive_lines = in_access;
	wire logic drive_data = in_access && write_reg;

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// Lines float when idle or granted; a pull keeps the level on the board
	assign bank_select_out = bank_reg;
	assign bank_select_oe_out = drive_lines;
	assign data_memory_address_out = addr_reg;
	assign data_memory_address_oe_out = drive_lines;
	assign data_memory_bus_out = wdata_reg;
	assign data_memory_bus_oe_out = drive_data;
	assign memory_read_strobe_n_out = ~read_strobe;
	assign memory_write_strobe_n_out = ~write_strobe;
	assign strobes_oe_out = drive_lines;
endmodule
`default_nettype wire

// ==== design/edmb_pkg.sv ====
// Summary of operation
// - The bank select output is low for an X memory access and high for a Y memory access.
// - After reset the address lines show all zeros until the first external access begins.
// - Between accesses the address lines keep the value of the most recent access.
// - Data moves over a 16-bit two-way bus, driven by the device on writes, sampled on reads.
// - The outside side may hold wait during a read, and the read stretches while it is held.
// - The device drives hold grant low while it lets an outside master use the bus.
// - The bus strobe is low for the whole time the device occupies the bus, high otherwise.
// - Bank select, address, data and read/write strobes float when idle or when grant is low.
`default_nettype none
package edmb_pkg;
	localparam int EDMB_ADDR_W = 16;
	localparam int EDMB_DATA_W = 16;
	localparam logic [15:0] EDMB_ADDR_RESET = 16'h0000;
	localparam logic [15:0] EDMB_DATA_RESET = 16'h0000;
	localparam logic EDMB_BANK_X = 1'b0;
	localparam logic EDMB_BANK_Y = 1'b1;
	typedef enum logic [1:0] {
		EDMB_IDLE,
		EDMB_SETUP,
		EDMB_STROBE,
		EDMB_HELD
	} edmb_state_e;
endpackage
`default_nettype wire

// ==== design/edmb_sync_if.sv ====
`default_nettype none
interface edmb_sync_if;
	logic wait_raw;
	logic hold_req_n_raw;
	logic wait_sync;
	logic hold_req_n_sync;
	modport syncer(input wait_raw, input hold_req_n_raw, output wait_sync, output hold_req_n_sync);
	modport user(output wait_raw, output hold_req_n_raw, input wait_sync, input hold_req_n_sync);
endinterface
`default_nettype wire

// ==== design/edmb_pin_sync.sv ====
`default_nettype none
module edmb_pin_sync (
	input wire logic clock_in,
	input wire logic reset_in,
	edmb_sync_if.syncer sync_bus
);
	logic [1:0] meta_reg;
	logic [1:0] stable_reg;
	// Request idles high so a reset never reads as a hold request
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			meta_reg <= 2'h2;
			stable_reg <= 2'h2;
		end else begin
			meta_reg <= {sync_bus.hold_req_n_raw, sync_bus.wait_raw};
			stable_reg <= meta_reg;
		end
	end
	assign sync_bus.wait_sync = stable_reg[0];
	assign sync_bus.hold_req_n_sync = stable_reg[1];
endmodule
`default_nettype wire

// ==== dv/edmb_ctrl_props.sv ====
`default_nettype none
module edmb_ctrl_props (
	input wire logic clock_in, reset_in, req_valid_in, req_ready_out, req_write_in, req_bank_y_in,
	input wire logic rsp_valid_out, bus_hold_grant_n_out, bus_occupied_strobe_n_out,
	input wire logic bus_hold_request_n_in, bank_select_out, bank_select_oe_out, strobes_oe_out,
	input wire logic data_memory_address_oe_out, data_memory_bus_oe_out,
	input wire logic memory_read_strobe_n_out, memory_write_strobe_n_out,
	input wire logic [15:0] req_addr_in, data_memory_address_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	wire take = req_valid_in && req_ready_out;
	wire occ = !bus_occupied_strobe_n_out;
	wire rd = !memory_read_strobe_n_out;
	wire wr = !memory_write_strobe_n_out;
	occ_oe_match_a: assert property (occ == strobes_oe_out && occ == data_memory_address_oe_out)
		else $error("occupied strobe and enables disagree");
	float_held_a: assert property (!bus_hold_grant_n_out |-> !strobes_oe_out && !bank_select_oe_out
		&& !data_memory_address_oe_out && !data_memory_bus_oe_out) else $error("bus driven in hold");
	one_strobe_a: assert property ((rd || wr) |-> !(rd && wr) && strobes_oe_out)
		else $error("strobes overlap or float");
	addr_stable_a: assert property (occ && $past(occ) |-> $stable(data_memory_address_out)
		&& $stable(bank_select_out)) else $error("address moved in access");
	addr_kept_a: assert property (!occ |-> $stable(data_memory_address_out))
		else $error("address moved while idle");
	write_walk_a: assert property (take && req_write_in |=> occ && bank_select_out == $past(
		req_bank_y_in) && data_memory_address_out == $past(req_addr_in) ##1 wr ##1 rsp_valid_out)
		else $error("write cycle wrong");
	read_walk_a: assert property (take && !req_write_in |=> occ && !data_memory_bus_oe_out
		##1 rd ##[1:20] rsp_valid_out) else $error("read cycle wrong");
	grant_excl_a: assert property (!bus_hold_grant_n_out |-> !occ && !req_ready_out)
		else $error("grant during access");
	grant_end_a: assert property ($rose(bus_hold_grant_n_out) |-> $past(bus_hold_request_n_in, 2))
		else $error("grant ended early");
	read_min_a: assert property ($fell(memory_read_strobe_n_out) |=> rd)
		else $error("read strobe too short");
	cover property (take && req_write_in);
	cover property (rd [*3]);
	cover property ($fell(bus_hold_grant_n_out));
endmodule
`default_nettype wire

// ==== dv/edmb_mem_model.sv ====
`default_nettype none
module edmb_mem_model (
	input wire logic clock_in, occ_n_in, rd_n_in, wr_n_in, bank_in, data_oe_in,
	input wire logic [15:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic [3:0] waits_in,
	output logic wait_out,
	output logic [15:0] rdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [512];
	logic [15:0] last;
	logic [3:0] cnt;
	// Wait raised from setup on, since the pin passes a synchroniser
	assign wait_out = !occ_n_in && cnt < waits_in;
	// Undriven bus shows the inverse, not a stale word
	assign rdata_out = !rd_n_in ? mem[{bank_in, addr_in[7:0]}] : ~last;
	always @(posedge clock_in) begin
		cnt <= occ_n_in ? 4'h0 : cnt + {3'h0, cnt < waits_in};
		if (!rd_n_in) last <= rdata_out;
		// A write with the data lines undriven stores nothing
		if (!wr_n_in && data_oe_in) mem[{bank_in, addr_in[7:0]}] <= wdata_in;
	end
endmodule
`default_nettype wire

// ==== dv/edmb_ctrl_tb.sv ====
`default_nettype none
module edmb_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in, reset_in, req_valid_in, req_write_in, req_bank_y_in, req_ready_out;
	logic rsp_valid_out, wait_in, bus_hold_request_n_in, bus_hold_grant_n_out;
	logic bus_occupied_strobe_n_out, bank_select_out, bank_select_oe_out, strobes_oe_out;
	logic data_memory_address_oe_out, data_memory_bus_oe_out;
	logic memory_read_strobe_n_out, memory_write_strobe_n_out;
	logic [15:0] req_addr_in, req_wdata_in, rsp_rdata_out, data_memory_address_out;
	logic [15:0] data_memory_bus_in, data_memory_bus_out, q;
	logic [3:0] waits;
	int num_errors, n_compared, n, m;
	edmb_ctrl u_edmb_ctrl (.clock_in(clock_in), .reset_in(reset_in),
		.req_valid_in(req_valid_in), .req_write_in(req_write_in),
		.req_bank_y_in(req_bank_y_in), .req_addr_in(req_addr_in),
		.req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
		.rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out), .wait_in(wait_in),
		.bus_hold_request_n_in(bus_hold_request_n_in),
		.bus_hold_grant_n_out(bus_hold_grant_n_out),
		.bus_occupied_strobe_n_out(bus_occupied_strobe_n_out),
		.bank_select_out(bank_select_out), .bank_select_oe_out(bank_select_oe_out),
		.data_memory_address_out(data_memory_address_out),
		.data_memory_address_oe_out(data_memory_address_oe_out),
		.data_memory_bus_in(data_memory_bus_in), .data_memory_bus_out(data_memory_bus_out),
		.data_memory_bus_oe_out(data_memory_bus_oe_out),
		.memory_read_strobe_n_out(memory_read_strobe_n_out),
		.memory_write_strobe_n_out(memory_write_strobe_n_out),
		.strobes_oe_out(strobes_oe_out));
	edmb_mem_model u_edmb_mem_model (.clock_in(clock_in), .occ_n_in(bus_occupied_strobe_n_out),
		.rd_n_in(memory_read_strobe_n_out), .wr_n_in(memory_write_strobe_n_out),
		.bank_in(bank_select_out), .data_oe_in(data_memory_bus_oe_out),
		.addr_in(data_memory_address_out),
		.wdata_in(data_memory_bus_out), .waits_in(waits), .wait_out(wait_in),
		.rdata_out(data_memory_bus_in));
	initial begin
		clock_in = 0;
		forever #50 clock_in = ~clock_in;
	end
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Bounded wait on a level, gives up into the verdict
	task automatic until_is(ref logic s, input logic v);
		int k;
		for (k = 0; k < 60 && s !== v; k++) @(negedge clock_in);
		if (s !== v) begin
			num_errors++;
			give_verdict();
		end
	endtask
	task automatic acc(input logic w, y, input logic [15:0] a, d, output int c);
		@(negedge clock_in);
		{req_valid_in, req_write_in, req_bank_y_in, req_addr_in, req_wdata_in} = {1'b1, w, y, a, d};
		until_is(req_ready_out, 1'b1);
		@(negedge clock_in);
		req_valid_in = 0;
		for (c = 1; c < 60 && rsp_valid_out !== 1'b1; c++) @(negedge clock_in);
		until_is(rsp_valid_out, 1'b1);
		q = rsp_rdata_out;
	endtask
	task automatic t_reset();
		chk(16'h0000, data_memory_address_out);
		chk(16'h0003, {14'h0, bus_hold_grant_n_out, bus_occupied_strobe_n_out});
		$display("reset test done");
	endtask
	task automatic t_rw();
		acc(1, 0, 16'h00c3, 16'h1234, n);
		acc(1, 1, 16'h00c3, 16'habcd, n);
		acc(0, 0, 16'h00c3, 16'h0000, n);
		chk(16'h1234, q);
		acc(0, 1, 16'h00c3, 16'h0000, n);
		chk(16'habcd, q);
		repeat (3) @(negedge clock_in);
		chk(16'h00c3, data_memory_address_out);
		chk(16'h0000, {15'h0, data_memory_address_oe_out});
		$display("read write test done");
	endtask
	task automatic t_wait();
		acc(0, 1, 16'h00c3, 16'h0000, n);
		waits = 4'h3;
		acc(0, 1, 16'h00c3, 16'h0000, m);
		waits = 4'h0;
		chk(16'habcd, q);
		chk(16'h0001, {15'h0, m > n});
		$display("wait test done");
	endtask
	task automatic t_hold();
		@(negedge clock_in);
		bus_hold_request_n_in = 0;
		acc(1, 0, 16'h0042, 16'h5a5a, n);
		chk(16'h0001, {15'h0, bus_hold_grant_n_out});
		until_is(bus_hold_grant_n_out, 1'b0);
		repeat (4) @(negedge clock_in);
		chk(16'h0000, {14'h0, req_ready_out, strobes_oe_out});
		bus_hold_request_n_in = 1;
		until_is(bus_hold_grant_n_out, 1'b1);
		acc(0, 0, 16'h00c3, 16'h0000, n);
		chk(16'h1234, q);
		acc(0, 0, 16'h0042, 16'h0000, n);
		chk(16'h5a5a, q);
		$display("hold test done");
	endtask
	task automatic t_reset_mid();
		@(negedge clock_in);
		reset_in = 1;
		@(negedge clock_in);
		chk(16'h0000, data_memory_address_out);
		reset_in = 0;
		@(negedge clock_in);
		chk(16'h0003, {14'h0, bus_hold_grant_n_out, bus_occupied_strobe_n_out});
		chk(16'h0000, data_memory_address_out);
		acc(0, 1, 16'h00c3, 16'h0000, n);
		chk(16'habcd, q);
		$display("mid-run reset test done");
	endtask
	initial begin
		reset_in = 1;
		{req_valid_in, req_write_in, req_bank_y_in} = 3'h0;
		{req_addr_in, req_wdata_in} = 32'h0;
		bus_hold_request_n_in = 1;
		waits = 4'h0;
		num_errors = 0;
		n_compared = 0;
		repeat (2) @(negedge clock_in);
		reset_in = 0;
		t_reset();
		t_rw();
		t_wait();
		t_hold();
		t_reset_mid();
		give_verdict();
	end
endmodule
bind edmb_ctrl edmb_ctrl_props u_edmb_ctrl_props (.clock_in(clock_in), .reset_in(reset_in),
	.req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_write_in(req_write_in),
	.req_bank_y_in(req_bank_y_in), .rsp_valid_out(rsp_valid_out),
	.bus_hold_grant_n_out(bus_hold_grant_n_out),
	.bus_occupied_strobe_n_out(bus_occupied_strobe_n_out),
	.bus_hold_request_n_in(bus_hold_request_n_in), .bank_select_out(bank_select_out),
	.bank_select_oe_out(bank_select_oe_out), .strobes_oe_out(strobes_oe_out),
	.data_memory_address_oe_out(data_memory_address_oe_out),
	.data_memory_bus_oe_out(data_memory_bus_oe_out),
	.memory_read_strobe_n_out(memory_read_strobe_n_out),
	.memory_write_strobe_n_out(memory_write_strobe_n_out), .req_addr_in(req_addr_in),
	.data_memory_address_out(data_memory_address_out));
`default_nettype wire
